// file: design/dcpsc_params.svh
/*
 * Constants for the dual converter phase and soft-start control core:
 * register offsets, field positions, reset values and counts.
 * Assumes it is included by bare name from the soft-start and control design files.
 */
`ifndef DCPSC_PARAMS_SVH
`define DCPSC_PARAMS_SVH

// Register byte offsets
`define DCPSC_ADDR_OSC_PERIOD     5'h00
`define DCPSC_ADDR_MAX_ON_FIRST   5'h04
`define DCPSC_ADDR_MAX_ON_SECOND  5'h08
`define DCPSC_ADDR_STATUS         5'h0C
`define DCPSC_ADDR_REF            5'h10

// Reset values and minimum oscillator period
`define DCPSC_OSC_PERIOD_RST      16'h0064
`define DCPSC_OSC_PERIOD_MIN      16'h0004
`define DCPSC_MAX_ON_RST          16'h0028
`define DCPSC_WAIT_RST            1'h1

// Status field positions
`define DCPSC_ST_UNDERVOLTAGE_LOCKOUT             0
`define DCPSC_ST_TSD              1
`define DCPSC_ST_SYNC_ACTIVE      2
`define DCPSC_ST_DIV_CLK          3
`define DCPSC_ST_PGOOD_PIN        4
`define DCPSC_ST_SS_DONE          6
`define DCPSC_ST_FOLDBACK         8
`define DCPSC_ST_SWITCH           10

// Reference field positions
`define DCPSC_REF_FIRST_LSB       0
`define DCPSC_REF_SECOND_LSB      8

// Soft-start counts
`define DCPSC_SS_TICKS_PER_STEP   5'h1F
`define DCPSC_SS_STEPS            7'h40

// Sync loss: free oscillator ticks without a sync edge
`define DCPSC_SYNC_MISS_LIMIT     3'h4

`endif

// file: design/dcpsc_pkg.sv
/*
 * Types for the dual converter phase and soft-start control core.
 * Assumes users refer to every item as dcpsc_pkg::name.
 */
package dcpsc_pkg;

	typedef enum logic [1:0] {
		DCPSC_CH_OFF,
		DCPSC_CH_RAMP,
		DCPSC_CH_REG
	} dcpsc_ch_state_t;

endpackage : dcpsc_pkg

// file: design/dcpsc_softstart.sv
/*
 * Soft-start reference ramp for one converter channel.
 * Assumes osc_tick_i is a one-cycle pulse per oscillator period on sys_clk_i
 * and clear_i is held while the channel may not run.
 */
`timescale 1ns/1ps
`include "dcpsc_params.svh"

module dcpsc_softstart (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       clear_i,
	input  wire logic       osc_tick_i,
	// Ramp state
	output logic      [6:0] ref_code_o,
	output logic            done_o
);

	logic [4:0] div_ff;
	logic [6:0] ref_ff;

	// Step every 32 ticks, hold at 64
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || clear_i)
		begin
			div_ff <= 5'h00;
			ref_ff <= 7'h00;
		end
		else if (osc_tick_i && (ref_ff != `DCPSC_SS_STEPS))
		begin
			if (div_ff == `DCPSC_SS_TICKS_PER_STEP)
			begin
				div_ff <= 5'h00;
				ref_ff <= ref_ff + 7'h01;
			end
			else
			begin
				div_ff <= div_ff + 5'h01;
			end
		end
	end

	assign ref_code_o = ref_ff;
	assign done_o     = (ref_ff == `DCPSC_SS_STEPS);

endmodule : dcpsc_softstart

// file: design/dcpsc_ctrl.sv
/*
 * Control core of a two-channel switching converter: oscillator with sync
 * alignment, divide-by-two anti-phase turn-on, 45 degree clock output,
 * per-channel soft-start, power-good, current limit, foldback, thermal and
 * undervoltage shutdown, and an Avalon-MM register slave with waitrequest.
 * Assumes comparator and pin inputs are asynchronous to sys_clk_i and that
 * power-good pins are open drain resolved outside.
 */
`timescale 1ns/1ps
`include "dcpsc_params.svh"

// Functional notes
// - Switching clock is oscillator divided by two
// - Channel turn-ons are half a period apart
// - First on rising, second on falling edge
// - Sync rising edge realigns the oscillator
// - Without sync edges, free-run internal oscillator
// - Clock output lags turn-on by 45 degrees
// - Undervoltage lockout forces both switches off
// - Ramp reference in 64 steps once enabled
// - Whole ramp lasts 2048 oscillator cycles
// - Enable rise restarts that channel's ramp only
// - Enable low disables channel, power-good low
// - Output-low comparator pulls power-good low
// - Current limit ends on-time until next pulse
// - Feedback low quarters that channel's frequency
// - Over-temperature: switches off, power-good low, reset ramp
// - Leave thermal shutdown only on cooled indication
module dcpsc_ctrl (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire logic  [4:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic  [3:0] avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Shared pin and comparator inputs
	input  wire logic        sync_i,
	input  wire logic        undervoltage_lockout_i,
	input  wire logic        over_temp_i,
	input  wire logic        cooled_i,
	// First channel inputs
	input  wire logic        enable_first_converter_i,
	input  wire logic        out_low_first_i,
	input  wire logic        cur_limit_first_i,
	input  wire logic        feedback_node_low_first_i,
	input  wire logic        power_ok_first_i,
	// Second channel inputs
	input  wire logic        enable_second_converter_i,
	input  wire logic        out_low_second_i,
	input  wire logic        cur_limit_second_i,
	input  wire logic        feedback_node_low_second_i,
	input  wire logic        power_ok_second_i,
	// Switch drives and clock output
	output logic             switch_first_o,
	output logic             switch_second_o,
	output logic             phase_shifted_clock_out_o,
	// Open-drain power-good pins
	output logic             power_ok_first_o,
	output logic             power_ok_first_oe_n_o,
	output logic             power_ok_second_o,
	output logic             power_ok_second_oe_n_o,
	// Soft-start references
	output logic       [6:0] ref_first_o,
	output logic       [6:0] ref_second_o
);

	// Input bank positions
	localparam int NIN      = 14;
	localparam int I_SYNC   = 0;
	localparam int I_UNDERVOLTAGE_LOCKOUT   = 1;
	localparam int I_OTEMP  = 2;
	localparam int I_COOLED = 3;
	localparam int I_EN     = 4;
	localparam int I_OLOW   = 6;
	localparam int I_ILIM   = 8;
	localparam int I_FBLOW  = 10;
	localparam int I_PGPIN  = 12;

	logic [NIN-1:0] pin_raw;
	logic [NIN-1:0] meta_ff;
	logic [NIN-1:0] pin_ff;
	logic           sync_d_ff;
	logic     [1:0] en_d_ff;

	logic    [15:0] osc_period_ff;
	logic    [15:0] max_on_first_ff;
	logic    [15:0] max_on_second_ff;
	logic    [15:0] osc_cnt_ff;
	logic           div_clk_ff;
	logic           clk_out_ff;
	logic     [2:0] sync_miss_ff;
	logic           tsd_ff;

	logic           sync_edge;
	logic           osc_tick;
	logic     [1:0] start;
	logic     [1:0] en;
	logic     [1:0] olow;
	logic     [1:0] ilim;
	logic     [1:0] fblow;
	logic           undervoltage_lockout;

	logic           wait_ff;
	logic    [31:0] rdata_ff;
	logic    [31:0] rmux;
	logic    [31:0] status;
	logic           req;
	logic           acc_wr;

	logic     [1:0] ss_done;
	logic     [1:0] fold_act;
	logic     [6:0] ref_code [2];

	assign pin_raw = {power_ok_second_i, power_ok_first_i,
		feedback_node_low_second_i, feedback_node_low_first_i,
		cur_limit_second_i, cur_limit_first_i,
		out_low_second_i, out_low_first_i,
		enable_second_converter_i, enable_first_converter_i,
		cooled_i, over_temp_i, undervoltage_lockout_i, sync_i};

	// Two-stage synchronisers for all pins
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			meta_ff <= '0;
			pin_ff  <= '0;
		end
		else
		begin
			meta_ff <= pin_raw;
			pin_ff  <= meta_ff;
		end
	end

	// Edge history for sync and enables
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			sync_d_ff <= 1'h0;
			en_d_ff   <= 2'h0;
		end
		else
		begin
			sync_d_ff <= pin_ff[I_SYNC];
			en_d_ff   <= en;
		end
	end

	assign undervoltage_lockout  = pin_ff[I_UNDERVOLTAGE_LOCKOUT];
	assign en    = pin_ff[I_EN+1:I_EN];
	assign olow  = pin_ff[I_OLOW+1:I_OLOW];
	assign ilim  = pin_ff[I_ILIM+1:I_ILIM];
	assign fblow = pin_ff[I_FBLOW+1:I_FBLOW];

	assign sync_edge = pin_ff[I_SYNC] & ~sync_d_ff;
	assign osc_tick  = sync_edge | (osc_cnt_ff >= (osc_period_ff - 16'h0001));

	// Oscillator, realigned by each sync edge
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			osc_cnt_ff <= 16'h0000;
		else if (osc_tick)
			osc_cnt_ff <= 16'h0000;
		else
			osc_cnt_ff <= osc_cnt_ff + 16'h0001;
	end

	// Divide by two for the switching clock
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			div_clk_ff <= 1'h0;
		else if (osc_tick)
			div_clk_ff <= ~div_clk_ff;
	end

	assign start[0] = osc_tick & ~div_clk_ff;
	assign start[1] = osc_tick & div_clk_ff;

	// Clock output a quarter oscillator period late
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			clk_out_ff <= 1'h0;
		else if (osc_cnt_ff == ({2'h0, osc_period_ff[15:2]} - 16'h0001))
			clk_out_ff <= div_clk_ff;
	end

	// Free ticks since the last sync edge
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			sync_miss_ff <= `DCPSC_SYNC_MISS_LIMIT;
		else if (sync_edge)
			sync_miss_ff <= 3'h0;
		else if (osc_tick && (sync_miss_ff != `DCPSC_SYNC_MISS_LIMIT))
			sync_miss_ff <= sync_miss_ff + 3'h1;
	end

	// Thermal shutdown, trip wins over cooled
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			tsd_ff <= 1'h0;
		else if (pin_ff[I_OTEMP])
			tsd_ff <= 1'h1;
		else if (pin_ff[I_COOLED])
			tsd_ff <= 1'h0;
	end

	// Per-channel sequencing and switch control
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_ch
			logic                      run;
			logic                      clear;
			logic                      fire;
			logic               [15:0] max_on;
			logic                [1:0] fold_ff;
			logic               [15:0] on_cnt_ff;
			logic                      sw_ff;
			logic                      pg_oe_n_ff;
			logic                      pg_ff;
			dcpsc_pkg::dcpsc_ch_state_t state_ff;

			assign max_on = (ch == 0) ? max_on_first_ff : max_on_second_ff;
			assign run    = ~undervoltage_lockout & ~tsd_ff & en[ch];
			// Ramp restarts on lockout, shutdown, disable or enable rise
			assign clear  = ~run | (en[ch] & ~en_d_ff[ch]);
			assign fire   = start[ch] & run & (~fblow[ch] | (fold_ff == 2'h0));
			assign fold_act[ch] = fblow[ch];

			dcpsc_softstart u_ss (
				.sys_clk_i  (sys_clk_i),
				.rst_i      (rst_i),
				.clear_i    (clear),
				.osc_tick_i (osc_tick),
				.ref_code_o (ref_code[ch]),
				.done_o     (ss_done[ch])
			);

			// Counts own clock pulses for foldback
			always_ff @(posedge sys_clk_i)
			begin
				if (rst_i)
					fold_ff <= 2'h0;
				else if (start[ch])
					fold_ff <= fold_ff + 2'h1;
			end

			// On-time control
			always_ff @(posedge sys_clk_i)
			begin
				if (rst_i || !run)
				begin
					sw_ff     <= 1'h0;
					on_cnt_ff <= 16'h0000;
				end
				else if (ilim[ch])
				begin
					sw_ff     <= 1'h0;
					on_cnt_ff <= 16'h0000;
				end
				else if (fire)
				begin
					sw_ff     <= 1'h1;
					on_cnt_ff <= 16'h0000;
				end
				else if (sw_ff)
				begin
					if (on_cnt_ff >= (max_on - 16'h0001))
						sw_ff <= 1'h0;
					on_cnt_ff <= on_cnt_ff + 16'h0001;
				end
			end

			// Channel state
			always_ff @(posedge sys_clk_i)
			begin
				if (rst_i || clear)
					state_ff <= dcpsc_pkg::DCPSC_CH_OFF;
				else
				begin
					case (state_ff)
						dcpsc_pkg::DCPSC_CH_OFF:  state_ff <= dcpsc_pkg::DCPSC_CH_RAMP;
						dcpsc_pkg::DCPSC_CH_RAMP:
							if (ss_done[ch])
								state_ff <= dcpsc_pkg::DCPSC_CH_REG;
						dcpsc_pkg::DCPSC_CH_REG:  state_ff <= dcpsc_pkg::DCPSC_CH_REG;
						default:                  state_ff <= dcpsc_pkg::DCPSC_CH_OFF;
					endcase
				end
			end

			// Power-good: released only when regulating and not low
			always_ff @(posedge sys_clk_i)
			begin
				if (rst_i)
				begin
					pg_oe_n_ff <= 1'h0;
					pg_ff      <= 1'h0;
				end
				else
				begin
					pg_oe_n_ff <= run && (state_ff == dcpsc_pkg::DCPSC_CH_REG)
						&& !olow[ch];
					pg_ff      <= 1'h0;
				end
			end
		end
	endgenerate

	assign switch_first_o            = g_ch[0].sw_ff;
	assign switch_second_o           = g_ch[1].sw_ff;
	assign phase_shifted_clock_out_o = clk_out_ff;
	assign power_ok_first_o          = g_ch[0].pg_ff;
	assign power_ok_first_oe_n_o     = g_ch[0].pg_oe_n_ff;
	assign power_ok_second_o         = g_ch[1].pg_ff;
	assign power_ok_second_oe_n_o    = g_ch[1].pg_oe_n_ff;
	assign ref_first_o               = ref_code[0];
	assign ref_second_o              = ref_code[1];

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] be_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		logic [15:0] r;
		r = old_v;
		if (be[0])
			r[7:0] = new_v[7:0];
		if (be[1])
			r[15:8] = new_v[15:8];
		return r;
	endfunction : be_merge

	assign req    = avs_read_i | avs_write_i;
	assign acc_wr = avs_write_i & ~wait_ff;

	always_comb
	begin
		status = 32'h0000_0000;
		status[`DCPSC_ST_UNDERVOLTAGE_LOCKOUT]          = undervoltage_lockout;
		status[`DCPSC_ST_TSD]           = tsd_ff;
		status[`DCPSC_ST_SYNC_ACTIVE]   = (sync_miss_ff != `DCPSC_SYNC_MISS_LIMIT);
		status[`DCPSC_ST_DIV_CLK]       = div_clk_ff;
		status[`DCPSC_ST_PGOOD_PIN+1 -: 2] = pin_ff[I_PGPIN+1:I_PGPIN];
		status[`DCPSC_ST_SS_DONE+1 -: 2]   = ss_done;
		status[`DCPSC_ST_FOLDBACK+1 -: 2]  = fold_act;
		status[`DCPSC_ST_SWITCH]        = g_ch[0].sw_ff;
		status[`DCPSC_ST_SWITCH+1]      = g_ch[1].sw_ff;
	end

	always_comb
	begin
		case (avs_address_i)
			`DCPSC_ADDR_OSC_PERIOD:    rmux = {16'h0000, osc_period_ff};
			`DCPSC_ADDR_MAX_ON_FIRST:  rmux = {16'h0000, max_on_first_ff};
			`DCPSC_ADDR_MAX_ON_SECOND: rmux = {16'h0000, max_on_second_ff};
			`DCPSC_ADDR_STATUS:        rmux = status;
			`DCPSC_ADDR_REF:           rmux = {17'h0_0000, ref_code[1], 1'h0, ref_code[0]};
			default:                   rmux = 32'h0000_0000;
		endcase
	end

	// One wait cycle, then a one-cycle answer
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			wait_ff <= `DCPSC_WAIT_RST;
		else if (req && wait_ff)
			wait_ff <= 1'h0;
		else
			wait_ff <= 1'h1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			rdata_ff <= 32'h0000_0000;
		else if (avs_read_i && wait_ff)
			rdata_ff <= rmux;
	end

	assign avs_waitrequest_o = wait_ff;
	assign avs_readdata_o    = rdata_ff;

	// Writable registers
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			osc_period_ff    <= `DCPSC_OSC_PERIOD_RST;
			max_on_first_ff  <= `DCPSC_MAX_ON_RST;
			max_on_second_ff <= `DCPSC_MAX_ON_RST;
		end
		else if (acc_wr)
		begin
			case (avs_address_i)
				`DCPSC_ADDR_OSC_PERIOD:
					if (be_merge(osc_period_ff, avs_writedata_i[15:0],
						avs_byteenable_i[1:0]) < `DCPSC_OSC_PERIOD_MIN)
						osc_period_ff <= `DCPSC_OSC_PERIOD_MIN;
					else
						osc_period_ff <= be_merge(osc_period_ff,
							avs_writedata_i[15:0], avs_byteenable_i[1:0]);
				`DCPSC_ADDR_MAX_ON_FIRST:
					max_on_first_ff <= be_merge(max_on_first_ff,
						avs_writedata_i[15:0], avs_byteenable_i[1:0]);
				`DCPSC_ADDR_MAX_ON_SECOND:
					max_on_second_ff <= be_merge(max_on_second_ff,
						avs_writedata_i[15:0], avs_byteenable_i[1:0]);
				default:
					max_on_first_ff <= max_on_first_ff;
			endcase
		end
	end

endmodule : dcpsc_ctrl

// file: tb/dcpsc_sync_src.sv
/*
 * Model of an external sync clock source with 50 percent duty, standing
 * in for a master device whose clock output feeds this sync input.
 * Assumes sys_clk_i as its time base; the output stands low when stopped.
 */
`timescale 1ns/1ps

module dcpsc_sync_src #(
	parameter int HALF = 8
) (
	// Clock
	input  wire logic sys_clk_i,
	// Control
	input  wire logic run_i,
	// Sync pin
	output logic      sync_o
);
	int cnt = 0;

	initial sync_o = 1'h0;

	always @(posedge sys_clk_i)
	begin
		cnt <= (run_i && cnt < HALF - 1) ? cnt + 1 : 0;
		if (!run_i)
			sync_o <= 1'h0;
		else if (cnt == HALF - 1)
			sync_o <= !sync_o;
	end
endmodule : dcpsc_sync_src

// file: tb/dcpsc_ctrl_assertions.sv
/*
 * Concurrent checks on the control core ports.
 * Assumes it is bound to dcpsc_ctrl; inputs take three or four cycles to act.
 */
`timescale 1ns/1ps

module dcpsc_ctrl_assertions (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// Watched inputs
	input  wire logic       undervoltage_lockout_i,
	input  wire logic       over_temp_i,
	input  wire logic       enable_first_converter_i,
	input  wire logic       out_low_first_i,
	input  wire logic       cur_limit_first_i,
	// Watched outputs
	input  wire logic       switch_first_o,
	input  wire logic       switch_second_o,
	input  wire logic       power_ok_first_oe_n_o,
	input  wire logic       power_ok_second_oe_n_o,
	input  wire logic [6:0] ref_first_o,
	input  wire logic [6:0] ref_second_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	undervoltage_lockout_sw_off_a:
	assert property (undervoltage_lockout_i [*6] |-> !switch_first_o && !switch_second_o)
		else $error("switch on in lockout");
	undervoltage_lockout_ramp_clr_a:
	assert property (undervoltage_lockout_i [*6] |-> ref_first_o == 7'h00 && ref_second_o == 7'h00)
		else $error("ramp not cleared in lockout");
	anti_phase_a:
	assert property (!($rose(switch_first_o) && $rose(switch_second_o)))
		else $error("both switches turned on together");
	ref_step_a:
	assert property ($changed(ref_first_o) |-> ref_first_o == $past(ref_first_o) + 7'h01
		|| ref_first_o == 7'h00)
		else $error("reference jumped");
	ref_hold_a:
	assert property (ref_first_o <= 7'h40 && ref_second_o <= 7'h40)
		else $error("reference above final code");
	en_low_off_a:
	assert property (!enable_first_converter_i [*6] |-> !switch_first_o && !power_ok_first_oe_n_o)
		else $error("disabled channel active");
	out_low_pg_a:
	assert property (out_low_first_i [*6] |-> !power_ok_first_oe_n_o)
		else $error("power good released while output low");
	limit_cut_a:
	assert property (cur_limit_first_i [*6] |-> !(switch_first_o && $past(switch_first_o)))
		else $error("on time not ended by current limit");
	thermal_off_a:
	assert property (over_temp_i [*6] |-> !switch_first_o && !switch_second_o
		&& !power_ok_first_oe_n_o && !power_ok_second_oe_n_o)
		else $error("active during thermal trip");

	ramp_end_c: cover property (ref_first_o == 7'h40);
	turn_on_c: cover property ($rose(switch_first_o));
	trip_c: cover property (over_temp_i [*6]);
endmodule : dcpsc_ctrl_assertions

bind dcpsc_ctrl dcpsc_ctrl_assertions u_chk (.*);

// file: tb/tb_dcpsc_ctrl.sv
/*
 * Bench for the control core: registers, ramp, phasing, faults, sync.
 * Assumes the sync source model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end

module tb_dcpsc_ctrl;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic  [4:0] adr = 5'h00;
	logic        rd = 1'h0;
	logic        wr = 1'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic        wq;
	logic        srun = 1'h0;
	logic        sync;
	logic        undervoltage_lockout = 1'h1;
	logic        ot = 1'h0;
	logic        cool = 1'h0;
	logic  [1:0] en = 2'h0;
	logic  [1:0] olow = 2'h0;
	logic  [1:0] clim = 2'h0;
	logic  [1:0] fbl = 2'h0;
	logic        sw1, sw2, clko, oe1, oe2, pd1, pd2;
	logic  [6:0] ref1, ref2;
	logic [31:0] d;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          r1 = 0, r2 = 0, h1 = 0, t1 = 0, t2 = 0, tc = 0, s1, s2, sh;
	logic        p1 = 1'h0, p2 = 1'h0, pc = 1'h0;
	logic        seq = 1'h0;

	dcpsc_sync_src #(.HALF(8)) u_sync (.sys_clk_i(clk), .run_i(srun), .sync_o(sync));

	dcpsc_ctrl u_dut (
		.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wq), .sync_i(sync),
		.undervoltage_lockout_i(undervoltage_lockout), .over_temp_i(ot), .cooled_i(cool),
		.enable_first_converter_i(en[0]), .out_low_first_i(olow[0]),
		.cur_limit_first_i(clim[0]), .feedback_node_low_first_i(fbl[0]),
		.power_ok_first_i(oe1 ? 1'h1 : pd1),
		.enable_second_converter_i(seq ? (oe1 ? 1'h1 : pd1) : en[1]),
		.out_low_second_i(olow[1]), .cur_limit_second_i(clim[1]),
		.feedback_node_low_second_i(fbl[1]), .power_ok_second_i(oe2 ? 1'h1 : pd2),
		.switch_first_o(sw1), .switch_second_o(sw2), .phase_shifted_clock_out_o(clko),
		.power_ok_first_o(pd1), .power_ok_first_oe_n_o(oe1), .power_ok_second_o(pd2),
		.power_ok_second_oe_n_o(oe2), .ref_first_o(ref1), .ref_second_o(ref2)
	);

	always #2 clk = !clk;

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
			test_done(1'h1);
	end

	// Edge and high-cycle counters, last turn-on and clock-out rise times
	always @(negedge clk)
	begin
		r1 += int'(sw1 && !p1);
		r2 += int'(sw2 && !p2);
		h1 += int'(sw1);
		if (sw1 && !p1)
			t1 = cyc;
		if (sw2 && !p2)
			t2 = cyc;
		if (clko && !pc)
			tc = cyc;
		p1 = sw1;
		p2 = sw2;
		pc = clko;
	end

	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] v);
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= {16'h0000, v};
		do
			@(posedge clk);
		while (wq !== 1'h0);
		d = rdat;
		wr <= 1'h0;
		rd <= 1'h0;
	endtask : bus

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	task automatic snap(input int n);
		s1 = r1;
		s2 = r2;
		sh = h1;
		wt(n);
	endtask : snap

	task automatic test_done(input logic hang);
		if (hang)
			mismatches++;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	initial
	begin
		wt(16);
		rst <= 1'h0;
		bus(1'h0, 5'h00, 16'h0000);
		`CHK(d[15:0], 16'h0064);
		bus(1'h0, 5'h14, 16'h0000);
		`CHK(d, 32'h0);
		bus(1'h0, 5'h0C, 16'h0000);
		`CHK(d[2:0], 3'h1);
		`CHK({sw1, sw2, ref1}, 9'h000);
		bus(1'h1, 5'h00, 16'h0001);
		bus(1'h0, 5'h00, 16'h0000);
		`CHK(d[15:0], 16'h0004);
		bus(1'h1, 5'h04, 16'h0002);
		bus(1'h1, 5'h08, 16'h0002);
		en <= 2'h3;
		undervoltage_lockout <= 1'h0;
		wt(2112);
		`CHK(ref1, 7'h10);
		wt(6016);
		`CHK(ref1, 7'h3F);
		wt(128);
		`CHK({ref1, ref2, oe1}, 15'h4081);
		snap(64);
		`CHK(r1 - s1, 8);
		`CHK(r2 - s2, 8);
		`CHK(h1 - sh, 16);
		`CHK((t2 - t1 + 8) % 8, 4);
		`CHK((tc - t1 + 8) % 8, 1);
		fbl <= 2'h1;
		wt(8);
		snap(64);
		`CHK(r1 - s1, 2);
		`CHK(r2 - s2, 8);
		fbl <= 2'h0;
		bus(1'h1, 5'h04, 16'h0003);
		clim <= 2'h1;
		snap(64);
		`CHK(h1 - sh <= 8, 1'h1);
		clim <= 2'h0;
		olow <= 2'h1;
		wt(10);
		`CHK(oe1, 1'h0);
		olow <= 2'h0;
		en <= 2'h2;
		wt(8);
		snap(64);
		`CHK({r1 - s1, r2 - s2}, {32'h0, 32'h8});
		`CHK({oe1, oe2}, 2'h1);
		en <= 2'h3;
		wt(200);
		`CHK({ref1, ref2}, 14'h00C0);
		bus(1'h1, 5'h00, 16'h0014);
		srun <= 1'h1;
		snap(100);
		snap(160);
		`CHK(r1 - s1, 5);
		bus(1'h0, 5'h0C, 16'h0000);
		`CHK(d[2], 1'h1);
		srun <= 1'h0;
		snap(200);
		snap(160);
		`CHK(r1 - s1, 4);
		bus(1'h1, 5'h00, 16'h0004);
		ot <= 1'h1;
		wt(10);
		`CHK({sw1, sw2, oe1, oe2, pd1, pd2, ref1, ref2}, 20'h0);
		ot <= 1'h0;
		wt(100);
		bus(1'h0, 5'h0C, 16'h0000);
		`CHK({d[1], ref1}, 8'h80);
		cool <= 1'h1;
		wt(8);
		cool <= 1'h0;
		wt(200);
		`CHK(ref1, 7'h01);
		seq <= 1'h1;
		wt(10);
		`CHK({ref2, sw2, oe2}, 9'h000);
		undervoltage_lockout <= 1'h1;
		wt(10);
		`CHK({sw1, sw2, ref1, ref2}, 16'h0);
		test_done(1'h0);
	end
endmodule : tb_dcpsc_ctrl
